// [dmac_pkg.sv]
// Purpose: Shared constants, types and helpers of the DMA channel controller
// Assumes: Seven channels, 32-bit Avalon-MM register port
// Notes:   Byte offsets of the register window, control field positions
package dmac_pkg;

  localparam int NCH = 7;

  // Register window (byte addresses)
  localparam logic [7:0] OFS_FLAG      = 8'h00;
  localparam logic [7:0] OFS_CLEAR     = 8'h04;
  localparam logic [7:0] OFS_CH_BASE   = 8'h08;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h14;
  localparam logic [7:0] SUB_CTL       = 8'h00;
  localparam logic [7:0] SUB_CNT       = 8'h04;
  localparam logic [7:0] SUB_PADDR     = 8'h08;
  localparam logic [7:0] SUB_MADDR     = 8'h0c;

  // Channel control field positions
  localparam int CTL_W  = 15;
  localparam int B_EN   = 0;
  localparam int B_FIE  = 1;
  localparam int B_HIE  = 2;
  localparam int B_EIE  = 3;
  localparam int B_DIR  = 4;
  localparam int B_CIRC = 5;
  localparam int B_PINC = 6;
  localparam int B_MINC = 7;
  localparam int B_PW   = 8;
  localparam int B_MW   = 10;
  localparam int B_SW_URGENCY_LEVEL = 12;
  localparam int B_M2M  = 14;

  // Flag nibble per channel, channel x at bits 4x+3..4x
  localparam int FLG_ANY  = 0;
  localparam int FLG_FULL = 1;
  localparam int FLG_HALF = 2;
  localparam int FLG_ERR  = 3;

  localparam logic [CTL_W-1:0] CTL_RST = 15'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b11
  } dmac_eng_e;

  function automatic logic [31:0] dmac_step(input logic [1:0] w);
    return (w == 2'h0) ? 32'h1 : (w == 2'h1) ? 32'h2 : 32'h4;
  endfunction : dmac_step

  function automatic logic [31:0] dmac_wmask(input logic [1:0] w);
    return (w == 2'h0) ? 32'h0000_00ff : (w == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction : dmac_wmask

endpackage : dmac_pkg

// [dmac_if.sv]
// Purpose: Carriers between the controller core, its arbiter and flag bank
// Assumes: dmac_pkg compiled first
// Notes:   Grant is registered inside the arbiter
`timescale 1ns/1ns
interface dmac_arb_if;
  import dmac_pkg::*;
  logic [NCH-1:0]      pend;
  logic [NCH-1:0][1:0] urg;
  logic                gnt_valid;
  logic [2:0]          gnt_ch;
  modport core (output pend, output urg, input gnt_valid, input gnt_ch);
  modport arb  (input pend, input urg, output gnt_valid, output gnt_ch);
endinterface : dmac_arb_if

interface dmac_evt_if;
  import dmac_pkg::*;
  logic [NCH-1:0]      full_set;
  logic [NCH-1:0]      half_set;
  logic [NCH-1:0]      err_set;
  logic [NCH-1:0]      clr_all;
  logic [NCH-1:0]      clr_full;
  logic [NCH-1:0]      clr_half;
  logic [NCH-1:0]      clr_err;
  logic [NCH-1:0][2:0] ie;
  logic [NCH-1:0][3:0] flg;
  logic [NCH-1:0]      irq;
  modport core (output full_set, output half_set, output err_set, output clr_all,
                output clr_full, output clr_half, output clr_err, output ie,
                input flg, input irq);
  modport bank (input full_set, input half_set, input err_set, input clr_all,
                input clr_full, input clr_half, input clr_err, input ie,
                output flg, output irq);
endinterface : dmac_evt_if

// [dmac_arbiter.sv]
// Purpose: Two-stage channel arbiter, urgency first, then channel number
// Assumes: Pending vector already qualified by the core
// Notes:   Grant is one cycle behind pending; the core rechecks it
`timescale 1ns/1ns
module dmac_arbiter
  import dmac_pkg::*;
(
  // Clock and reset
  input logic  clk,
  input logic  reset,
  // Core side
  dmac_arb_if.arb ab
);

  typedef struct packed {
    logic       valid;
    logic [2:0] ch;
  } dmac_arb_s;

  dmac_arb_s  s;
  dmac_arb_s  n;
  logic [1:0] best;
  logic       better;

  always_comb
  begin
    n       = s;
    n.valid = 1'b0;
    best    = 2'h0;
    // Strict compare keeps the lower channel on equal urgency
    for (int i = 0; i < NCH; i++)
    begin
      if (ab.pend[i] && (!n.valid || ab.urg[i] > best))
      begin
        n.valid = 1'b1;
        n.ch    = 3'(i);
        best    = ab.urg[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s <= '0;
    else
      s <= n;
  end

  assign ab.gnt_valid = s.valid;
  assign ab.gnt_ch    = s.ch;

  // Helper: some pending channel beats the chosen one
  always_comb
  begin
    better = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      if (ab.pend[i] && (ab.urg[i] > ab.urg[n.ch] ||
          (ab.urg[i] == ab.urg[n.ch] && 3'(i) < n.ch)))
        better = 1'b1;
    end
  end

  a_grant_best: assert property (@(posedge clk) disable iff (reset)
    n.valid |-> !better)
    else $error("arbiter chose a channel that does not win");

  a_grant_idle: assert property (@(posedge clk) disable iff (reset)
    !(|ab.pend) |=> !ab.gnt_valid)
    else $error("grant without any pending channel");

endmodule : dmac_arbiter

// [dmac_flag_bank.sv]
// Purpose: Per-channel event flags and interrupt lines
// Assumes: Set and clear strobes are one-cycle pulses from the core
// Notes:   A set in the same cycle as its clear wins, so no event is lost
`timescale 1ns/1ns
module dmac_flag_bank
  import dmac_pkg::*;
(
  // Clock and reset
  input logic  clk,
  input logic  reset,
  // Core side
  dmac_evt_if.bank ev
);

  typedef struct packed {
    logic [NCH-1:0][3:0] flg;
    logic [NCH-1:0]      irq;
  } dmac_flag_s;

  dmac_flag_s s;
  dmac_flag_s n;
  logic [3:0] f;

  always_comb
  begin
    n = s;
    f = 4'h0;
    for (int i = 0; i < NCH; i++)
    begin
      f = s.flg[i];
      if (ev.clr_all[i])
        f = 4'h0;
      if (ev.clr_full[i])
        f[FLG_FULL] = 1'b0;
      if (ev.clr_half[i])
        f[FLG_HALF] = 1'b0;
      if (ev.clr_err[i])
        f[FLG_ERR] = 1'b0;
      if (ev.full_set[i])
        f[FLG_FULL] = 1'b1;
      if (ev.half_set[i])
        f[FLG_HALF] = 1'b1;
      if (ev.err_set[i])
        f[FLG_ERR] = 1'b1;
      if (ev.full_set[i] | ev.half_set[i] | ev.err_set[i])
        f[FLG_ANY] = 1'b1;
      n.flg[i] = f;
      n.irq[i] = |(f[FLG_ERR:FLG_FULL] & ev.ie[i]);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s <= '0;
    else
      s <= n;
  end

  assign ev.flg = s.flg;
  assign ev.irq = s.irq;

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_chk
      a_set_wins: assert property (@(posedge clk) disable iff (reset)
        ev.full_set[g] |=> (s.flg[g][FLG_FULL] && s.flg[g][FLG_ANY]))
        else $error("full event lost against a clear");
      a_irq_gate: assert property (@(posedge clk) disable iff (reset)
        s.irq[g] == |(s.flg[g][FLG_ERR:FLG_FULL] & $past(ev.ie[g])))
        else $error("interrupt does not follow enabled flags");
    end
  endgenerate

endmodule : dmac_flag_bank

// [dmac_top.sv]
// Purpose: Seven-channel DMA controller with Avalon-MM register port
// Assumes: One bus master port shared by all channels; peripheral
//          request lines are asynchronous and synchronised here
// Notes:   Flags and interrupt lines live in the flag bank
// Operation
// - Count loaded first, shows items remaining
// - Clearing enable stops channel activity
// - Re-enable without config write resumes transfer
// - Count or address write forces fresh start
// - Re-enabling finished channel starts nothing
// - Acknowledge once peripheral access command issued
// - Highest urgency pending channel wins
// - Equal urgency: lowest channel number wins
// - Separate increment select, peripheral and memory
// - Fixed mode always uses base address
// - Increment by 1, 2 or 4 bytes
// - Circular reloads count, full event each pass
// - Circular runs until enable cleared
// - Memory-to-memory starts at once, ends at zero
// - Three events, each flag, clear, enable
// - Interrupt when enabled event flag set
// - Channels 0 to 6, own request line
// - Urgency encoding, locked while enabled
// - Half flag at half of items
// - Any-flag set with any channel flag
// - Global clear wipes all four flags
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module dmac_top
  import dmac_pkg::*;
(
  // Clock and reset
  input  logic                clk,
  input  logic                reset,
  // Avalon-MM register slave
  input  logic [7:0]          avs_address,
  input  logic                avs_read,
  input  logic                avs_write,
  input  logic [31:0]         avs_writedata,
  input  logic [3:0]          avs_byteenable,
  output logic [31:0]         avs_readdata,
  output logic                avs_waitrequest,
  // Peripheral handshake, one pair per channel
  input  logic [NCH-1:0]      periph_req,
  output logic [NCH-1:0]      periph_ack,
  // Bus master command port
  output logic                mst_req,
  output logic                mst_write,
  output logic [31:0]         mst_addr,
  output logic [1:0]          mst_size,
  output logic [31:0]         mst_wdata,
  input  logic                mst_ready,
  input  logic [31:0]         mst_rdata,
  input  logic                mst_err,
  // Per-channel interrupts
  output logic [NCH-1:0]      chan_irq
);

  typedef struct packed {
    logic [NCH-1:0][CTL_W-1:0] ctl;
    logic [NCH-1:0][15:0]      cnt;
    logic [NCH-1:0][15:0]      reload;
    logic [NCH-1:0][31:0]      pbase;
    logic [NCH-1:0][31:0]      mbase;
    logic [NCH-1:0][31:0]      pcur;
    logic [NCH-1:0][31:0]      mcur;
    logic [NCH-1:0]            fresh;
    logic [NCH-1:0]            ack;
    logic [NCH-1:0]            req_m;
    logic [NCH-1:0]            req_s;
    dmac_eng_e                 st;
    logic [2:0]                ch;
    logic                      mreq;
    logic                      mwr;
    logic [31:0]               maddr;
    logic [1:0]                msize;
    logic [31:0]               mwdata;
    logic                      waitreq;
    logic [31:0]               rdata;
  } dmac_core_s;

  dmac_core_s     s;
  dmac_core_s     n;
  logic [NCH-1:0] pend;
  logic           acc;
  logic           do_wr;
  logic [31:0]    rd_mux;
  logic [31:0]    wv;
  logic [15:0]    nc;
  logic [2:0]     g;
  logic [2:0]     c;

  dmac_arb_if arb ();
  dmac_evt_if ev ();

  dmac_arbiter u_arb (
    .clk   (clk),
    .reset (reset),
    .ab    (arb.arb)
  );

  dmac_flag_bank u_flags (
    .clk   (clk),
    .reset (reset),
    .ev    (ev.bank)
  );

  function automatic logic [7:0] reg_ofs(input int i, input logic [7:0] sub);
    return 8'(OFS_CH_BASE + 8'(i) * OFS_CH_STRIDE + sub);
  endfunction : reg_ofs

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  // Qualified requests; the ack holds a channel off until its request drops
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      pend[i] = s.ctl[i][B_EN] && (s.cnt[i] != 16'h0) &&
                (s.ctl[i][B_M2M] || (s.req_s[i] && !s.ack[i]));
      arb.urg[i] = s.ctl[i][B_SW_URGENCY_LEVEL +: 2];
      ev.ie[i]   = {s.ctl[i][B_EIE], s.ctl[i][B_HIE], s.ctl[i][B_FIE]};
    end
    arb.pend = pend;
  end

  always_comb
  begin
    n           = s;
    ev.full_set = '0;
    ev.half_set = '0;
    ev.err_set  = '0;
    ev.clr_all  = '0;
    ev.clr_full = '0;
    ev.clr_half = '0;
    ev.clr_err  = '0;
    rd_mux      = 32'h0;
    wv          = 32'h0;
    nc          = 16'h0;
    g           = arb.gnt_ch;
    c           = s.ch;
    n.req_m     = periph_req;
    n.req_s     = s.req_m;
    for (int i = 0; i < NCH; i++)
    begin
      if (!s.req_s[i])
        n.ack[i] = 1'b0;
    end

    // Bus slave: one wait cycle, then the answer for exactly one cycle
    acc       = (avs_read | avs_write) & s.waitreq;
    do_wr     = avs_write & ~s.waitreq;
    n.waitreq = ~acc;
    if (avs_address == OFS_FLAG)
      rd_mux = {4'h0, ev.flg};
    for (int i = 0; i < NCH; i++)
    begin
      if (avs_address == reg_ofs(i, SUB_CTL))
        rd_mux = {17'h0, s.ctl[i]};
      if (avs_address == reg_ofs(i, SUB_CNT))
        rd_mux = {16'h0, s.cnt[i]};
      if (avs_address == reg_ofs(i, SUB_PADDR))
        rd_mux = s.pbase[i];
      if (avs_address == reg_ofs(i, SUB_MADDR))
        rd_mux = s.mbase[i];
    end
    if (acc)
      n.rdata = rd_mux;

    if (do_wr && avs_address == OFS_CLEAR)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ev.clr_all[i]  = avs_writedata[4 * i + FLG_ANY];
        ev.clr_full[i] = avs_writedata[4 * i + FLG_FULL];
        ev.clr_half[i] = avs_writedata[4 * i + FLG_HALF];
        ev.clr_err[i]  = avs_writedata[4 * i + FLG_ERR];
      end
    end

    for (int i = 0; i < NCH; i++)
    begin
      if (do_wr && avs_address == reg_ofs(i, SUB_CTL))
      begin
        wv = merge({17'h0, s.ctl[i]}, avs_writedata, avs_byteenable);
        if (s.ctl[i][B_EN])
          wv[B_M2M:B_SW_URGENCY_LEVEL] = s.ctl[i][B_M2M:B_SW_URGENCY_LEVEL];
        n.ctl[i] = wv[CTL_W-1:0];
        // A fresh start only after a count or address write
        if (wv[B_EN] && !s.ctl[i][B_EN] && s.fresh[i])
        begin
          n.pcur[i]  = s.pbase[i];
          n.mcur[i]  = s.mbase[i];
          n.cnt[i]   = s.reload[i];
          n.fresh[i] = 1'b0;
        end
      end
      if (do_wr && avs_address == reg_ofs(i, SUB_CNT))
      begin
        wv          = merge({16'h0, s.cnt[i]}, avs_writedata, avs_byteenable);
        n.cnt[i]    = wv[15:0];
        n.reload[i] = wv[15:0];
        n.fresh[i]  = 1'b1;
      end
      if (do_wr && avs_address == reg_ofs(i, SUB_PADDR))
      begin
        n.pbase[i] = merge(s.pbase[i], avs_writedata, avs_byteenable);
        n.fresh[i] = 1'b1;
      end
      if (do_wr && avs_address == reg_ofs(i, SUB_MADDR))
      begin
        n.mbase[i] = merge(s.mbase[i], avs_writedata, avs_byteenable);
        n.fresh[i] = 1'b1;
      end
    end

    // Transfer engine: read source, then write destination
    case (s.st)
      ST_IDLE:
      begin
        if (arb.gnt_valid && pend[g])
        begin
          n.ch   = g;
          n.mreq = 1'b1;
          n.mwr  = 1'b0;
          n.st   = ST_RD;
          if (s.ctl[g][B_DIR])
          begin
            n.maddr = s.ctl[g][B_MINC] ? s.mcur[g] : s.mbase[g];
            n.msize = s.ctl[g][B_MW +: 2];
          end
          else
          begin
            n.maddr = s.ctl[g][B_PINC] ? s.pcur[g] : s.pbase[g];
            n.msize = s.ctl[g][B_PW +: 2];
            if (!s.ctl[g][B_M2M])
              n.ack[g] = 1'b1;
          end
        end
      end
      ST_RD:
      begin
        if (mst_ready)
        begin
          if (mst_err)
          begin
            n.mreq          = 1'b0;
            n.st            = ST_IDLE;
            ev.err_set[c]   = 1'b1;
            n.ctl[c][B_EN]  = 1'b0;
          end
          else if (!s.ctl[c][B_EN])
          begin
            // Item dropped uncounted, so a resume repeats it
            n.mreq = 1'b0;
            n.st   = ST_IDLE;
          end
          else
          begin
            n.mwr    = 1'b1;
            n.st     = ST_WR;
            n.mwdata = mst_rdata & dmac_wmask(s.msize);
            if (s.ctl[c][B_DIR])
            begin
              n.maddr = s.ctl[c][B_PINC] ? s.pcur[c] : s.pbase[c];
              n.msize = s.ctl[c][B_PW +: 2];
              if (!s.ctl[c][B_M2M])
                n.ack[c] = 1'b1;
            end
            else
            begin
              n.maddr = s.ctl[c][B_MINC] ? s.mcur[c] : s.mbase[c];
              n.msize = s.ctl[c][B_MW +: 2];
            end
          end
        end
      end
      ST_WR:
      begin
        if (mst_ready)
        begin
          n.mreq = 1'b0;
          n.mwr  = 1'b0;
          n.st   = ST_IDLE;
          if (mst_err)
          begin
            ev.err_set[c]  = 1'b1;
            n.ctl[c][B_EN] = 1'b0;
          end
          else
          begin
            if (s.ctl[c][B_PINC])
              n.pcur[c] = s.pcur[c] + dmac_step(s.ctl[c][B_PW +: 2]);
            if (s.ctl[c][B_MINC])
              n.mcur[c] = s.mcur[c] + dmac_step(s.ctl[c][B_MW +: 2]);
            nc       = s.cnt[c] - 16'h1;
            n.cnt[c] = nc;
            if (nc == s.reload[c] - (s.reload[c] >> 1))
              ev.half_set[c] = 1'b1;
            if (nc == 16'h0)
            begin
              ev.full_set[c] = 1'b1;
              if (s.ctl[c][B_CIRC])
              begin
                n.cnt[c]  = s.reload[c];
                n.pcur[c] = s.pbase[c];
                n.mcur[c] = s.mbase[c];
              end
            end
          end
        end
      end
      default:
        n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s         <= '0;
      s.waitreq <= 1'b1;
    end
    else
      s <= n;
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign periph_ack      = s.ack;
  assign mst_req         = s.mreq;
  assign mst_write       = s.mwr;
  assign mst_addr        = s.maddr;
  assign mst_size        = s.msize;
  assign mst_wdata       = s.mwdata;
  assign chan_irq        = ev.irq;

  // Helpers for the checks below
  logic [15:0] cur_cnt;
  logic        cur_en;
  logic [2:0]  ch0_mode;
  assign cur_cnt  = s.cnt[s.ch];
  assign cur_en   = s.ctl[s.ch][B_EN];
  assign ch0_mode = s.ctl[0][B_M2M:B_SW_URGENCY_LEVEL];

  a_wait_release: assert property (@(posedge clk) disable iff (reset)
    acc |=> !avs_waitrequest)
    else $error("slave did not answer one cycle after the request");

  a_wait_single: assert property (@(posedge clk) disable iff (reset)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");

  a_ack_cmd: assert property (@(posedge clk) disable iff (reset)
    $rose(|periph_ack) |-> mst_req)
    else $error("acknowledge without a bus command");

  a_cnt_dec: assert property (@(posedge clk) disable iff (reset)
    (s.st == ST_WR && mst_ready && !mst_err && !s.ctl[s.ch][B_CIRC])
      |=> cur_cnt == $past(cur_cnt) - 16'h1)
    else $error("count did not drop by one item");

  a_err_stops: assert property (@(posedge clk) disable iff (reset)
    (s.st != ST_IDLE && mst_ready && mst_err) |=> (!cur_en && s.st == ST_IDLE))
    else $error("bus error did not stop the channel");

  a_urg_hold: assert property (@(posedge clk) disable iff (reset)
    s.ctl[0][B_EN] |=> ch0_mode == $past(ch0_mode))
    else $error("urgency or mode changed while enabled");

  a_idle_off: assert property (@(posedge clk) disable iff (reset)
    (s.st == ST_IDLE && !cur_en) |=> (s.st == ST_IDLE || s.ch != $past(s.ch)))
    else $error("disabled channel started a transfer");

endmodule : dmac_top

// [dmac_partner.sv]
// Purpose: Far-side model: request lines of peripherals and a bus slave
// Assumes: Command port of dmac_top, one clock
// Notes:   Addresses with top nibble f answer with an error response
`timescale 1ns/1ns
module dmac_partner
  import dmac_pkg::*;
(
  // Clock and reset
  input  logic                clk,
  input  logic                reset,
  // Peripheral side
  input  logic [NCH-1:0]      periph_ack,
  output logic [NCH-1:0]      periph_req,
  input  logic [NCH-1:0][3:0] quota,
  input  logic                quota_ld,
  // Bus slave side
  input  logic                mst_req,
  input  logic [31:0]         mst_addr,
  output logic                mst_ready,
  output logic [31:0]         mst_rdata,
  output logic                mst_err
);
  logic [NCH-1:0][3:0] cnt;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      periph_req <= '0;
      cnt        <= '0;
      mst_ready  <= 1'b0;
      mst_rdata  <= '0;
      mst_err    <= 1'b0;
    end
    else
    begin : live
      logic go;
      // Each peripheral asks for a counted number of items, one per ack
      for (int i = 0; i < NCH; i++)
      begin
        periph_req[i] <= !periph_ack[i] && (cnt[i] != 4'h0);
        if (quota_ld && quota[i] != 4'h0)
          cnt[i] <= quota[i];
        else if (periph_ack[i] && periph_req[i])
          cnt[i] <= cnt[i] - 4'h1; // drop after ack
      end
      // Prompt or slow answer; data lines churn outside the answer cycle
      go = mst_req && !mst_ready && ($urandom_range(1) == 0);
      mst_ready <= go;
      mst_rdata <= go ? (mst_addr ^ 32'h3c5a_a5c3) : ~mst_rdata;
      mst_err   <= go && (mst_addr[31:28] == 4'hf);
    end
  end
endmodule : dmac_partner

// [dmac_top_tb.sv]
// Purpose: Self-checking bench for the DMA channel controller
// Assumes: dmac_partner stands in for peripherals and memory
// Notes:   Bus writes and register reads are checked against queues
`timescale 1ns/1ns
module dmac_top_tb
  import dmac_pkg::*;
;
  logic                clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]          avs_address = '0;
  logic [31:0]         avs_writedata = '0, avs_readdata, mst_addr, mst_wdata, mst_rdata;
  logic                avs_waitrequest, mst_req, mst_write, mst_ready, mst_err;
  logic [NCH-1:0]      periph_req, periph_ack, chan_irq;
  logic [1:0]          mst_size;
  logic [NCH-1:0][3:0] quota = '0;
  logic                quota_ld = 1'b0;
  logic [65:0]         wq[$];
  logic [31:0]         rq[$];
  int                  mismatches = 0, n_checks = 0, cyc = 0;
  int                  u[6] = '{0, 0, 0, 2, 2, 3};
  int                  ord[4] = '{5, 3, 4, 1};

  always #4 clk = ~clk;

  dmac_top i_dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .periph_req, .periph_ack,
    .mst_req, .mst_write, .mst_addr, .mst_size, .mst_wdata, .mst_ready, .mst_rdata,
    .mst_err, .chan_irq);
  dmac_partner i_far (.clk, .reset, .periph_ack, .periph_req, .quota, .quota_ld,
    .mst_req, .mst_addr, .mst_ready, .mst_rdata, .mst_err);

  task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    chk("readdata", 66'(e), 66'(g));
  endtask : chk_rd

  task automatic chk_bus(input logic [65:0] e, input logic [65:0] g);
    chk("bus write", e, g);
  endtask : chk_bus

  task automatic chk_irq(input logic [NCH-1:0] e, input logic [NCH-1:0] g);
    chk("chan_irq", 66'(e), 66'(g));
  endtask : chk_irq

  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // Monitors take the oldest note whenever a result shows
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      end_of_test();
    end
    else
    begin
      if (avs_read && avs_waitrequest === 1'b0)
        chk_rd(rq.size() ? rq.pop_front() : 32'hx, avs_readdata);
      if (mst_req && mst_ready && mst_write)
        chk_bus(wq.size() ? wq.pop_front() : 66'hx, {mst_size, mst_addr, mst_wdata});
    end
  end

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask : rd

  function automatic logic [7:0] ra(input int ch, input logic [7:0] s);
    return OFS_CH_BASE + 8'(ch) * OFS_CH_STRIDE + s;
  endfunction : ra

  // Notes the expected destination writes of items k0 .. k0+n-1
  task automatic items(input logic [31:0] pb, mb, input logic [CTL_W-1:0] c, input int k0, n);
    logic [31:0] pa, ma, s, d;
    logic [1:0]  w, wd;
    for (int k = k0; k < k0 + n; k++)
    begin
      pa = c[B_PINC] ? pb + (k << c[B_PW+:2]) : pb;
      ma = c[B_MINC] ? mb + (k << c[B_MW+:2]) : mb;
      w = c[B_DIR] ? c[B_MW+:2] : c[B_PW+:2];
      s = c[B_DIR] ? ma : pa;
      d = c[B_DIR] ? pa : ma;
      wd = c[B_DIR] ? c[B_PW+:2] : c[B_MW+:2];
      wq.push_back({wd, d, (s ^ 32'h3c5a_a5c3) & 32'((64'h1 << (8 << w)) - 64'h1)});
    end
  endtask : items

  task automatic cfg(input int ch, input logic [CTL_W-1:0] c, input logic [15:0] n,
                     input logic [31:0] pb, mb);
    wr(ra(ch, SUB_CTL), 32'(c));
    wr(ra(ch, SUB_PADDR), pb);
    wr(ra(ch, SUB_MADDR), mb);
    wr(ra(ch, SUB_CNT), 32'(n));
    wr(ra(ch, SUB_CTL), 32'(c) | 32'h1);
  endtask : cfg

  task automatic give(input logic [NCH*4-1:0] q);
    quota <= q;
    quota_ld <= 1'b1;
    @(posedge clk);
    quota_ld <= 1'b0;
  endtask : give

  task automatic drain();
    while (wq.size() != 0) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : drain

  initial
  begin
    logic [31:0]      pb, mb;
    logic [CTL_W-1:0] c;
    void'($urandom(51832));
    pb = $urandom & 32'h0fff_fff0;
    mb = $urandom & 32'h0fff_fff0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_FLAG, 32'h0);
    rd(ra(6, SUB_CTL), 32'h0);
    wr(8'hfc, 32'hffff_ffff);
    rd(8'hfc, 32'h0);
    // Peripheral to memory, stopped halfway and resumed
    c = 15'h0986;
    cfg(2, c, 16'd4, pb, mb);
    items(pb, mb, c, 0, 2);
    give(28'h200);
    drain();
    rd(ra(2, SUB_CNT), 32'd2);
    rd(OFS_FLAG, 32'h500);
    chk_irq(7'h04, chan_irq);
    wr(ra(2, SUB_CTL), 32'(c) | 32'h3001);
    rd(ra(2, SUB_CTL), 32'(c) | 32'h1);
    wr(ra(2, SUB_CTL), 32'(c));
    give(28'h200);
    repeat (30) @(posedge clk);
    items(pb, mb, c, 2, 2);
    wr(ra(2, SUB_CTL), 32'(c) | 32'h1);
    drain();
    rd(OFS_FLAG, 32'h700);
    wr(ra(2, SUB_CTL), 32'(c));
    wr(ra(2, SUB_CTL), 32'(c) | 32'h1);
    give(28'h200);
    repeat (30) @(posedge clk);
    wr(OFS_CLEAR, 32'h100);
    rd(OFS_FLAG, 32'h0);
    chk_irq(7'h00, chan_irq);
    wr(ra(2, SUB_CTL), 32'(c));
    // Four channels asking at once
    for (int i = 1; i < 6; i++)
      if (i != 2)
        cfg(i, 15'h0a00 | (15'(u[i]) << B_SW_URGENCY_LEVEL), 16'd1, pb + 32'(i * 16), mb + 32'(i * 16));
    foreach (ord[i])
      items(pb + 32'(ord[i] * 16), mb + 32'(ord[i] * 16), 15'h0a00, 0, 1);
    give(28'h011_1010);
    drain();
    wr(OFS_CLEAR, 32'h0fff_ffff);
    // Circular, two passes and one more item
    c = 15'h00e2;
    cfg(6, c, 16'd2, pb, mb);
    repeat (2) items(pb, mb, c, 0, 2);
    give(28'h400_0000);
    drain();
    rd(ra(6, SUB_CNT), 32'd2);
    rd(OFS_FLAG, 32'h0700_0000);
    items(pb, mb, c, 0, 1);
    give(28'h100_0000);
    drain();
    wr(ra(6, SUB_CTL), 32'(c));
    wr(OFS_CLEAR, 32'h0fff_ffff);
    // Memory to memory, then a fresh start that hits a bus error
    c = 15'h4ac8;
    cfg(0, c, 16'd3, pb, mb);
    items(pb, mb, c, 0, 3);
    drain();
    rd(ra(0, SUB_CNT), 32'h0);
    wr(ra(0, SUB_CTL), 32'(c));
    wr(OFS_CLEAR, 32'h1);
    wr(ra(0, SUB_PADDR), 32'hf000_0000);
    wr(ra(0, SUB_CNT), 32'd3);
    wr(ra(0, SUB_CTL), 32'(c) | 32'h1);
    repeat (30) @(posedge clk);
    rd(OFS_FLAG, 32'h9);
    rd(ra(0, SUB_CTL), 32'(c));
    chk_irq(7'h01, chan_irq);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_FLAG, 32'h0);
    end_of_test();
  end
endmodule : dmac_top_tb
